//--- inc/mrad_pkg.sv
// Constants, types and register map of the region attribute decoder.
// Assumes one clock, synchronous reset and an APB register slave.
// Operation
// - Region size is two to size plus one
// - Base address low bit N equals size plus one
// - Missing permission or execute-never raises a fault
// - Type 000, C 0: strongly ordered or device
// - Type 000, C1 B0: write-through, S selects sharing
// - Type 000, C1 B1: write-back, S selects sharing
// - Type 001, C0 B0: non-cacheable normal memory
// - Type 001, C1 B1: write-back allocate; C0B1 reserved
// - Type 010, C0 B0: non-shared device; rest reserved
// - Type top set: cached normal, split policies
// - Policy codes: NC, WB-alloc, WT, WB-noalloc
// - Permission 000 denies every access
// - Permission 001: privileged read write only
// - Permission 010: unprivileged writes fault
// - Permission 011 full access; 100 reserved
// - Permission 101: privileged reads only
// - Permission 110 and 111: reads only
// - Violation raises the memory management fault
// - Fault cause recorded in status field
// - Execute-never is attribute bit 28
// - Permission code is attribute bits 26 to 24
// - Type bits 21:19, cacheable 17, bufferable 16
// - Shareable is attribute bit 18
package mrad_pkg;

    localparam int           APB_AW          = 8;
    localparam bit [7:0]     OFS_BASE        = 8'h00;
    localparam bit [7:0]     OFS_ATTR        = 8'h04;
    localparam bit [7:0]     OFS_CTRL        = 8'h08;
    localparam bit [7:0]     OFS_FSTAT       = 8'h0C;
    localparam bit [7:0]     OFS_FADDR       = 8'h10;
    localparam bit [7:0]     OFS_DECODE      = 8'h14;

    localparam bit [31:0]    ATTR_WMASK      = 32'h173F_FF3F;
    localparam bit [31:0]    ATTR_RST        = 32'h0000_0000;
    localparam bit [31:0]    BASE_RST        = 32'h0000_0000;

    localparam int           NOEXEC_BIT      = 28;
    localparam int           PERM_HI         = 26;
    localparam int           PERM_LO         = 24;
    localparam int           TYPE_HI         = 21;
    localparam int           TYPE_LO         = 19;
    localparam int           S_BIT           = 18;
    localparam int           C_BIT           = 17;
    localparam int           B_BIT           = 16;
    localparam int           SIZE_HI         = 5;
    localparam int           SIZE_LO         = 1;
    localparam int           EN_BIT          = 0;
    localparam bit [4:0]     SIZE_MIN        = 5'h04;

    localparam int           FS_IACC         = 0;
    localparam int           FS_DACC         = 1;
    localparam int           FS_ADDR_VALID   = 7;
    localparam int           FS_W            = 8;

    localparam bit [2:0]     TYPE_PLAIN      = 3'h0;
    localparam bit [2:0]     TYPE_NONCACHE   = 3'h1;
    localparam bit [2:0]     TYPE_DEVICE     = 3'h2;

    localparam bit [1:0]     POL_NC          = 2'h0;
    localparam bit [1:0]     POL_WB_ALLOC    = 2'h1;
    localparam bit [1:0]     POL_WT          = 2'h2;
    localparam bit [1:0]     POL_WB_NOALLOC  = 2'h3;

    localparam bit [2:0]     PERM_NONE       = 3'h0;
    localparam bit [2:0]     PERM_PRIV_RW    = 3'h1;
    localparam bit [2:0]     PERM_USER_RO    = 3'h2;
    localparam bit [2:0]     PERM_FULL       = 3'h3;
    localparam bit [2:0]     PERM_RSVD       = 3'h4;
    localparam bit [2:0]     PERM_PRIV_RO    = 3'h5;
    localparam bit [2:0]     PERM_RO         = 3'h6;
    localparam bit [2:0]     PERM_RO_ALT     = 3'h7;

    typedef enum logic [2:0] {
        MT_STRONG,
        MT_DEVICE,
        MT_NORMAL,
        MT_RESERVED
    } mrad_mtype_e;

    typedef enum logic [2:0] {
        CP_NC,
        CP_WB_ALLOC,
        CP_WT,
        CP_WB_NOALLOC
    } mrad_policy_e;

    typedef struct packed {
        mrad_mtype_e  mtype;
        logic         shareable;
        mrad_policy_e inner_cache_policy;
        mrad_policy_e outer_cache_policy;
    } mrad_attr_s;

    typedef struct packed {
        logic [31:0] addr;
        logic        priv;
        logic        write;
        logic        fetch;
    } mrad_acc_s;

endpackage

//--- design/mrad_attr_decode.sv
// Decodes one region attribute word into size, mask and memory attributes.
// Assumes a purely combinational use by the region checker.
`timescale 1ns/1ps
module mrad_attr_decode
    import mrad_pkg::*;
(
    input  wire logic [31:0]      attr_i,
    output mrad_pkg::mrad_attr_s  attr_o,
    output logic      [32:0]      size_bytes_o,
    output logic      [5:0]       low_bit_o,
    output logic      [31:0]      addr_mask_o
);

    logic [2:0] type_extension_bits;
    logic       cbit;
    logic       bbit;
    logic       sbit;
    logic [4:0] size_code;
    logic [32:0] size_less;

    function automatic mrad_policy_e policy(input logic [1:0] code);
        unique case (code)
            POL_NC:         policy = CP_NC;
            POL_WB_ALLOC:   policy = CP_WB_ALLOC;
            POL_WT:         policy = CP_WT;
            POL_WB_NOALLOC: policy = CP_WB_NOALLOC;
        endcase
    endfunction

    assign type_extension_bits = attr_i[TYPE_HI:TYPE_LO];
    assign cbit                = attr_i[C_BIT];
    assign bbit                = attr_i[B_BIT];
    assign sbit                = attr_i[S_BIT];
    assign size_code           = attr_i[SIZE_HI:SIZE_LO];

    assign low_bit_o    = 6'(size_code) + 6'h01;
    assign size_bytes_o = 33'h0_0000_0001 << low_bit_o;
    assign size_less    = size_bytes_o - 33'h0_0000_0001;
    assign addr_mask_o  = ~size_less[31:0];

    always_comb
    begin
        attr_o.mtype              = MT_RESERVED;
        attr_o.shareable          = 1'b0;
        attr_o.inner_cache_policy = CP_NC;
        attr_o.outer_cache_policy = CP_NC;
        if (type_extension_bits[2])
        begin
            attr_o.mtype              = MT_NORMAL;
            attr_o.shareable          = sbit;
            attr_o.inner_cache_policy = policy({cbit, bbit});
            attr_o.outer_cache_policy = policy(type_extension_bits[1:0]);
        end
        else
        begin
            unique case ({type_extension_bits, cbit, bbit})
                {TYPE_PLAIN, 2'b00}:
                begin
                    attr_o.mtype     = MT_STRONG;
                    attr_o.shareable = 1'b1;
                end
                {TYPE_PLAIN, 2'b01}:
                begin
                    attr_o.mtype     = MT_DEVICE;
                    attr_o.shareable = 1'b1;
                end
                {TYPE_PLAIN, 2'b10}:
                begin
                    attr_o.mtype              = MT_NORMAL;
                    attr_o.shareable          = sbit;
                    attr_o.inner_cache_policy = CP_WT;
                    attr_o.outer_cache_policy = CP_WT;
                end
                {TYPE_PLAIN, 2'b11}:
                begin
                    attr_o.mtype              = MT_NORMAL;
                    attr_o.shareable          = sbit;
                    attr_o.inner_cache_policy = CP_WB_NOALLOC;
                    attr_o.outer_cache_policy = CP_WB_NOALLOC;
                end
                {TYPE_NONCACHE, 2'b00}:
                begin
                    attr_o.mtype     = MT_NORMAL;
                    attr_o.shareable = sbit;
                end
                {TYPE_NONCACHE, 2'b11}:
                begin
                    attr_o.mtype              = MT_NORMAL;
                    attr_o.shareable          = sbit;
                    attr_o.inner_cache_policy = CP_WB_ALLOC;
                    attr_o.outer_cache_policy = CP_WB_ALLOC;
                end
                {TYPE_DEVICE, 2'b00}:
                begin
                    attr_o.mtype = MT_DEVICE;
                end
                default:
                begin
                    attr_o.mtype = MT_RESERVED;
                end
            endcase
        end
    end

endmodule // mrad_attr_decode

//--- design/mrad_top.sv
// Region checker: APB registers for one region, access check, fault record.
// Assumes the access port is driven by same-clock pipeline logic.
`timescale 1ns/1ps
module mrad_top
(
    input  wire logic                  core_clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [7:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    input  wire logic                  acc_valid_i,
    input  mrad_pkg::mrad_acc_s        acc_i,
    output logic                       acc_issue_o,
    output logic                       acc_fault_o,
    output mrad_pkg::mrad_attr_s       acc_attr_o,
    output logic                       memory_management_fault_o
);
    import mrad_pkg::*;

    logic [31:0]               region_base_address_word;
    logic [31:0]               region_attribute_word;
    logic                      checker_enable;
    logic [FS_W-1:0]           memory_fault_status_field;
    logic [31:0]               fault_addr;
    mrad_attr_s                dec_attr;
    logic [32:0]               size_bytes;
    logic [5:0]                low_bit;
    logic [31:0]               addr_mask;
    logic                      apb_setup;
    logic                      apb_write;
    logic                      apb_hit;
    logic [31:0]               next_rdata;
    logic                      region_hit;
    logic                      perm_ok;
    logic                      xn_block;
    logic                      fault_now;
    logic [FS_W-1:0]           fault_set;
    logic [FS_W-1:0]           fault_clr;
    logic [2:0]                access_permission_code;
    logic                      execute_never_bit;

    mrad_attr_decode u_decode
    (
        .attr_i       (region_attribute_word),
        .attr_o       (dec_attr),
        .size_bytes_o (size_bytes),
        .low_bit_o    (low_bit),
        .addr_mask_o  (addr_mask)
    );

    function automatic logic access_allowed(input logic [2:0] code, input logic priv,
                                            input logic wr);
        unique case (code)
            PERM_NONE:    access_allowed = 1'b0;
            PERM_PRIV_RW: access_allowed = priv;
            PERM_USER_RO: access_allowed = priv | ~wr;
            PERM_FULL:    access_allowed = 1'b1;
            PERM_RSVD:    access_allowed = 1'b0;
            PERM_PRIV_RO: access_allowed = priv & ~wr;
            PERM_RO:      access_allowed = ~wr;
            PERM_RO_ALT:  access_allowed = ~wr;
        endcase
    endfunction

    function automatic logic known_offset(input logic [7:0] ofs);
        known_offset = (ofs == OFS_BASE) || (ofs == OFS_ATTR) || (ofs == OFS_CTRL) ||
                       (ofs == OFS_FSTAT) || (ofs == OFS_FADDR) || (ofs == OFS_DECODE);
    endfunction

    // APB decode
    assign apb_setup = psel_i & ~penable_i;
    assign apb_write = psel_i & penable_i & pready_o & pwrite_i;
    assign apb_hit   = known_offset(paddr_i);

    // Field extraction
    assign access_permission_code = region_attribute_word[PERM_HI:PERM_LO];
    assign execute_never_bit      = region_attribute_word[NOEXEC_BIT];

    // Access check
    assign region_hit = region_attribute_word[EN_BIT] &
                        (((acc_i.addr ^ region_base_address_word) & addr_mask) == 32'h0000_0000);
    assign perm_ok    = access_allowed(access_permission_code, acc_i.priv,
                                       acc_i.write & ~acc_i.fetch);
    assign xn_block   = acc_i.fetch & execute_never_bit;
    assign fault_now  = acc_valid_i & checker_enable & region_hit &
                        (~perm_ok | xn_block);
    assign acc_fault_o = fault_now;
    assign acc_issue_o = acc_valid_i & ~fault_now;

    // Fault cause bits
    always_comb
    begin
        fault_set = '0;
        if (fault_now)
        begin
            fault_set[FS_IACC]       = acc_i.fetch;
            fault_set[FS_DACC]       = ~acc_i.fetch;
            fault_set[FS_ADDR_VALID] = ~acc_i.fetch;
        end
    end

    assign fault_clr = (apb_write && paddr_i == OFS_FSTAT) ? pwdata_i[FS_W-1:0] : '0;

    // APB handshake
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o  <= apb_setup;
            pslverr_o <= apb_setup & ~apb_hit;
        end
    end

    // Read data
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (paddr_i)
            OFS_BASE:   next_rdata = region_base_address_word;
            OFS_ATTR:   next_rdata = region_attribute_word;
            OFS_CTRL:   next_rdata = {31'h0000_0000, checker_enable};
            OFS_FSTAT:  next_rdata = {24'h00_0000, memory_fault_status_field};
            OFS_FADDR:  next_rdata = fault_addr;
            OFS_DECODE: next_rdata = {14'h0000, size_bytes[32], low_bit, 1'b0,
                                      dec_attr};
            default:    next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            prdata_o <= 32'h0000_0000;
        else if (apb_setup)
            prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
    end

    // Region configuration
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            region_base_address_word <= BASE_RST;
            region_attribute_word    <= ATTR_RST;
            checker_enable           <= 1'b0;
        end
        else if (apb_write)
        begin
            if (paddr_i == OFS_BASE)
                region_base_address_word <= pwdata_i & addr_mask;
            if (paddr_i == OFS_ATTR)
                region_attribute_word <= pwdata_i & ATTR_WMASK;
            if (paddr_i == OFS_CTRL)
                checker_enable <= pwdata_i[0];
        end
    end

    // Sticky fault status, set wins over clear
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            memory_fault_status_field <= '0;
        else
            memory_fault_status_field <= (memory_fault_status_field & ~fault_clr) |
                                         fault_set;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            fault_addr <= 32'h0000_0000;
        else if (fault_now && !acc_i.fetch)
            fault_addr <= acc_i.addr;
    end

    // Exception request pulse
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            memory_management_fault_o <= 1'b0;
        else
            memory_management_fault_o <= fault_now;
    end

    // Registered attributes of the configured region
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            acc_attr_o <= '0;
        else
            acc_attr_o <= dec_attr;
    end

endmodule // mrad_top

//--- dv/mrad_props.sv
// Checker for the region checker: APB timing, fault path and attribute decode.
// Assumes it is bound to mrad_top and sees only that module's ports.
`timescale 1ns/1ps
module mrad_props
    import mrad_pkg::*;
(
    input wire logic                 core_clk_i,
    input wire logic                 srst_i,
    input wire logic                 psel_i,
    input wire logic                 penable_i,
    input wire logic                 pwrite_i,
    input wire logic [7:0]           paddr_i,
    input wire logic [31:0]          pwdata_i,
    input wire logic [31:0]          prdata_o,
    input wire logic                 pready_o,
    input wire logic                 pslverr_o,
    input wire logic                 acc_valid_i,
    input mrad_pkg::mrad_acc_s       acc_i,
    input wire logic                 acc_issue_o,
    input wire logic                 acc_fault_o,
    input mrad_pkg::mrad_attr_s      acc_attr_o,
    input wire logic                 memory_management_fault_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    logic       wr_q;
    logic [5:0] code_q;

    // Last attribute write and its type, share, cacheable, bufferable bits
    always_ff @(posedge core_clk_i)
    begin
        wr_q <= !srst_i && psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFS_ATTR;
    end
    always_ff @(posedge core_clk_i)
    begin
        if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFS_ATTR)
            code_q <= pwdata_i[21:16];
    end

    sequence s_fault;
        acc_valid_i && acc_fault_o;
    endsequence
    sequence s_setup;
        psel_i && !penable_i;
    endsequence

    chk_issue_gate: assert property (acc_issue_o == (acc_valid_i && !acc_fault_o))
        else $error("issue not suppressed by fault");
    chk_fault_valid: assert property (acc_fault_o |-> acc_valid_i)
        else $error("fault without access");
    chk_mm_follow: assert property (s_fault |=> memory_management_fault_o)
        else $error("fault pulse missing");
    chk_mm_cause: assert property (memory_management_fault_o |-> $past(acc_fault_o))
        else $error("fault pulse without cause");
    chk_apb_ready: assert property (s_setup |=> pready_o)
        else $error("ready late");
    chk_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_dec_strong: assert property (wr_q && code_q[5:3] == 3'h0 && code_q[1:0] == 2'h0
        |=> acc_attr_o.mtype == MT_STRONG && acc_attr_o.shareable)
        else $error("strongly ordered decode wrong");
    chk_dec_device: assert property (wr_q && code_q[5:3] == 3'h2 && code_q[1:0] == 2'h0
        |=> acc_attr_o.mtype == MT_DEVICE && !acc_attr_o.shareable)
        else $error("non-shared device decode wrong");
    chk_dec_cached: assert property (wr_q && code_q[5]
        |=> acc_attr_o == {MT_NORMAL, code_q[2], 1'b0, code_q[1:0], 1'b0, code_q[4:3]})
        else $error("cached normal decode wrong");
    chk_dec_wthru: assert property (wr_q && code_q[5:3] == 3'h0 && code_q[1:0] == 2'h2
        |=> acc_attr_o == {MT_NORMAL, code_q[2], 3'h2, 3'h2})
        else $error("write-through decode wrong");
endmodule // mrad_props

bind mrad_top mrad_props u_mrad_props (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .acc_valid_i, .acc_i, .acc_issue_o,
    .acc_fault_o, .acc_attr_o, .memory_management_fault_o);

//--- dv/mrad_pipe_model.sv
// Load/store and fetch pipeline model: presents one access for one cycle.
// Assumes the fault answer is combinational within the same cycle.
`timescale 1ns/1ps
module mrad_pipe_model
    import mrad_pkg::*;
(
    input  wire logic            core_clk_i,
    input  wire logic            acc_fault_i,
    output logic                 acc_valid_o,
    output mrad_pkg::mrad_acc_s  acc_o
);
    initial
    begin
        acc_valid_o = 1'b0;
        acc_o       = '0;
    end

    // Idle cycles first, then one access; outcome taken at its closing edge
    task automatic access(input mrad_acc_s a, input int idle, output logic flt);
        repeat (idle) @(posedge core_clk_i);
        @(posedge core_clk_i);
        acc_valid_o <= 1'b1;
        acc_o       <= a;
        @(posedge core_clk_i);
        flt = acc_fault_i;
        acc_valid_o <= 1'b0;
        acc_o       <= ~a;
    endtask
endmodule // mrad_pipe_model

//--- dv/mrad_tb_top.sv
// Testbench for the region checker: APB register tasks and access scenarios.
// Assumes the pipeline model and the bound checker of this folder.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((exp) !== (got)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module mrad_tb_top;
    import mrad_pkg::*;
    localparam logic [31:0] BASE        = 32'h2000_0000;
    localparam logic [15:0] DEC_TAB [13] = '{16'h1040, 16'h04C0, 16'h090A, 16'h1D4F, 16'h3140,
        16'h2D05, 16'h2580, 16'h5080, 16'h4980, 16'hB949, 16'hCD0E, 16'h8100, 16'hF547};
    localparam logic [3:0]  PERM_FLT [8] = '{4'hF, 4'h3, 4'h2, 4'h0, 4'hF, 4'hB, 4'hA, 4'hA};
    localparam logic [4:0]  SIZES [5]   = '{5'h04, 5'h09, 5'h13, 5'h1D, 5'h1F};
    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, acc_valid, acc_fault, mm_fault, flt, err;
    logic [15:0] t;
    mrad_acc_s   acc;
    mrad_attr_s  attr;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    always #4 core_clk = ~core_clk;

    mrad_top u_mrad_top (.core_clk_i(core_clk), .srst_i(srst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .acc_valid_i(acc_valid),
        .acc_i(acc), .acc_issue_o(), .acc_fault_o(acc_fault), .acc_attr_o(attr),
        .memory_management_fault_o(mm_fault));
    mrad_pipe_model u_mrad_pipe_model (.core_clk_i(core_clk), .acc_fault_i(acc_fault),
        .acc_valid_o(acc_valid), .acc_o(acc));

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] mk(logic xn, logic [2:0] ap, logic [5:0] code,
                                       logic [4:0] sz);
        return {3'h0, xn, 1'b0, ap, 2'h0, code, 8'h00, 2'h0, sz, 1'b1};
    endfunction

    task automatic go(logic [31:0] ad, logic pv, logic wr, logic fe, logic exp, int idle);
        u_mrad_pipe_model.access('{ad, pv, wr, fe}, idle, flt);
        `CHK("fault", exp, flt)
    endtask

    task automatic finish_test;
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        apb(1'b0, OFS_ATTR, 32'h0000_0000);
        `CHK("attr_rst", ATTR_RST, rd)
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        `CHK("ctrl_rst", 32'h0000_0000, rd)
        apb(1'b0, 8'h18, 32'h0000_0000);
        `CHK("unmapped", 33'h1_0000_0000, {err, rd})
        foreach (DEC_TAB[i])
        begin
            t = DEC_TAB[i];
            apb(1'b1, OFS_ATTR, mk(1'b0, PERM_FULL, t[15:10], 5'h04));
            repeat (2) @(posedge core_clk);
            `CHK("mtype", t[9:7], attr.mtype)
            if (t[9:7] != 3'h3)
                `CHK("share", t[6], attr.shareable)
            if (t[9:7] == 3'h2)
                `CHK("policy", {1'b0, t[3:2], 1'b0, t[1:0]}, {attr[5:3], attr[2:0]})
        end
        foreach (SIZES[i])
        begin
            apb(1'b1, OFS_ATTR, mk(1'b0, PERM_FULL, 6'h00, SIZES[i]));
            apb(1'b0, OFS_DECODE, 32'h0000_0000);
            `CHK("low_bit", {1'b0, SIZES[i]} + 6'h01, rd[16:11])
            `CHK("size_4g", SIZES[i] == 5'h1F, rd[17])
        end
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        for (int ap = 0; ap < 8; ap++)
        begin
            apb(1'b1, OFS_ATTR, mk(1'b0, ap[2:0], 6'h00, 5'h09));
            apb(1'b1, OFS_BASE, BASE);
            for (int k = 0; k < 4; k++)
                go(BASE + 32'h0000_0100, k[1], k[0], 1'b0, PERM_FLT[ap][k], k);
        end
        apb(1'b1, OFS_ATTR, mk(1'b0, PERM_NONE, 6'h00, 5'h09));
        apb(1'b1, OFS_FSTAT, 32'h0000_0083);
        apb(1'b0, OFS_FSTAT, 32'h0000_0000);
        `CHK("fstat_clr", 32'h0000_0000, rd)
        go(BASE + 32'h0000_03FC, 1'b1, 1'b0, 1'b0, 1'b1, 0);
        go(BASE + 32'h0000_0400, 1'b1, 1'b0, 1'b0, 1'b0, 0);
        go(BASE - 32'h0000_0004, 1'b1, 1'b1, 1'b0, 1'b0, 0);
        apb(1'b0, OFS_FSTAT, 32'h0000_0000);
        `CHK("fstat_data", 32'h0000_0082, rd)
        apb(1'b0, OFS_FADDR, 32'h0000_0000);
        `CHK("fault_addr", BASE + 32'h0000_03FC, rd)
        apb(1'b1, OFS_ATTR, mk(1'b1, PERM_FULL, 6'h00, 5'h09));
        go(BASE, 1'b1, 1'b0, 1'b1, 1'b1, 0);
        go(BASE, 1'b1, 1'b0, 1'b0, 1'b0, 0);
        apb(1'b0, OFS_FSTAT, 32'h0000_0000);
        `CHK("fstat_fetch", 1'b1, rd[0])
        apb(1'b1, OFS_ATTR, mk(1'b0, PERM_FULL, 6'h00, 5'h09));
        go(BASE, 1'b0, 1'b0, 1'b1, 1'b0, 1);
        apb(1'b1, OFS_ATTR, mk(1'b0, PERM_NONE, 6'h00, 5'h09));
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        go(BASE, 1'b0, 1'b1, 1'b0, 1'b0, 0);
        finish_test();
    end
endmodule // mrad_tb_top
